// ==== design/oag_params.svh ====
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH
// Specifier field positions
`define OAG_REG_LSB      0
`define OAG_REG_MSB      2
`define OAG_MODE_LSB     3
`define OAG_MODE_MSB     5
`define OAG_DEFER_BIT    3
// Special registers
`define OAG_SP_IDX       3'h6
`define OAG_PC_IDX       3'h7
// Step sizes
`define OAG_STEP_WORD    16'h0002
`define OAG_STEP_BYTE    16'h0001
// Reset values
`define OAG_REG_RST      16'h0000
`define OAG_PC_RST       16'h0000
`endif

// ==== design/oag_pkg.sv ====
package oag_pkg;
  typedef enum logic [2:0] {
    OAG_M_REG, OAG_M_REGDEF, OAG_M_AINC, OAG_M_AINCDEF,
    OAG_M_ADEC, OAG_M_ADECDEF, OAG_M_IDX, OAG_M_IDXDEF
  } oag_mode_t;
  typedef enum logic [1:0] {
    OAG_OP_ZERO, OAG_OP_INVERT, OAG_OP_PLUS_ONE, OAG_OP_ADD
  } oag_op_t;
endpackage

// ==== design/oag_spec_decode.sv ====
`timescale 1ns/10ps
`include "oag_params.svh"
// Splits one operand specifier into register, mode and step
module oag_spec_decode (
  input  wire logic [5:0]         spec,
  input  wire logic               byte_op,
  output oag_pkg::oag_mode_t      mode,
  output logic      [2:0]         regn,
  output logic                    deferred,
  output logic      [15:0]        step
);
  import oag_pkg::*;
  wire sp_or_pc;
  assign regn     = spec[`OAG_REG_MSB:`OAG_REG_LSB];
  assign mode     = oag_mode_t'(spec[`OAG_MODE_MSB:`OAG_MODE_LSB]);
  assign deferred = spec[`OAG_DEFER_BIT];
  assign sp_or_pc = (regn == `OAG_SP_IDX) || (regn == `OAG_PC_IDX);
  // Deferred modes always step a word since the register points at an address
  assign step = (byte_op && !deferred && !sp_or_pc) ? `OAG_STEP_BYTE : `OAG_STEP_WORD;
endmodule

// ==== design/oag_alu.sv ====
`timescale 1ns/10ps
// Result of the operation on the destination operand
module oag_alu (
  input  wire logic [1:0]   op,
  input  wire logic         byte_op,
  input  wire logic [15:0]  src,
  input  wire logic [15:0]  dst,
  output logic      [15:0]  res
);
  import oag_pkg::*;
  wire [15:0] raw;
  assign raw = (op == OAG_OP_ZERO)   ? 16'h0000 :
               (op == OAG_OP_INVERT) ? ~dst :
               (op == OAG_OP_PLUS_ONE) ? dst + 16'h0001 : src + dst;
  assign res = byte_op ? {8'h00, raw[7:0]} : raw;
endmodule

// ==== design/oag_operand_addr_gen.sv ====
`timescale 1ns/10ps
`include "oag_params.svh"
// What this block does
// - Specifier low three register, upper three mode
// - Mode 0 operand is the register
// - Autoincrement and index fetches through PC add two
// - Byte op on register touches low byte
// - Autoincrement steps one or two, SP/PC two
// - Register advanced first, source still fetched at old pointer
// - Autodecrement reduces register, then addresses
// - Index adds following word, only PC advanced
// - Mode 1 register holds operand address
// - Mode 3 reads pointer word, adds two
// - Mode 5 subtracts two, reads pointer
// - Mode 7 index then read pointer
// - First extension source, second destination
// - Invert every bit, write back
module oag_operand_addr_gen (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire logic          start,
  input  wire logic [5:0]    src_spec,
  input  wire logic [5:0]    dst_spec,
  input  wire logic          two_operand,
  input  wire oag_pkg::oag_op_t op,
  input  wire logic          byte_op,
  input  wire logic          mem_ack,
  input  wire logic [15:0]   mem_rdata,
  output logic               mem_req,
  output logic               mem_we,
  output logic      [15:0]   mem_addr,
  output logic      [15:0]   mem_wdata,
  output logic               mem_byte,
  output logic               done,
  output logic      [15:0]   pc_out
);
  import oag_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_SEL, S_PRE, S_EXT, S_PTR, S_OPND, S_ALU, S_WR, S_DONE
  } oag_state_t;

  oag_state_t  state_q;
  logic [15:0] gpr_q [8];
  logic        side_q;        // 0 source, 1 destination
  logic [15:0] ea_q;
  logic [15:0] src_val_q;
  logic [15:0] dst_val_q;
  logic        mem_req_q, mem_we_q, mem_byte_q, done_q;
  logic [15:0] mem_addr_q, mem_wdata_q;

  oag_mode_t   s_mode, d_mode;
  logic [2:0]  s_reg, d_reg;
  logic        s_def, d_def;
  logic [15:0] s_step, d_step;

  oag_spec_decode u_src (
    .spec     (src_spec),
    .byte_op  (byte_op),
    .mode     (s_mode),
    .regn     (s_reg),
    .deferred (s_def),
    .step     (s_step)
  );
  oag_spec_decode u_dst (
    .spec     (dst_spec),
    .byte_op  (byte_op),
    .mode     (d_mode),
    .regn     (d_reg),
    .deferred (d_def),
    .step     (d_step)
  );

  // Current specifier selection
  wire oag_mode_t  cur_mode = side_q ? d_mode : s_mode;
  wire [2:0]       cur_reg  = side_q ? d_reg  : s_reg;
  wire [15:0]      cur_step = side_q ? d_step : s_step;
  wire [15:0]      cur_rv   = gpr_q[cur_reg];
  wire [15:0]      pc_v     = gpr_q[`OAG_PC_IDX];
  wire             cur_def  = side_q ? d_def : s_def;
  wire             is_reg   = (cur_mode == OAG_M_REG);
  wire             is_inc   = (cur_mode == OAG_M_AINC) || (cur_mode == OAG_M_AINCDEF);
  wire             is_dec   = (cur_mode == OAG_M_ADEC) || (cur_mode == OAG_M_ADECDEF);
  wire             is_idx   = (cur_mode == OAG_M_IDX)  || (cur_mode == OAG_M_IDXDEF);
  wire [15:0]      dec_val  = cur_rv - cur_step;
  wire [15:0]      inc_val  = cur_rv + cur_step;
  // Word operands are kept even; odd-address trapping lives elsewhere
  wire             word_acc = !byte_op || (cur_def && state_q == S_PTR);
  wire [15:0]      opnd_ea  = byte_op ? ea_q : {ea_q[15:1], 1'b0};
  wire             ack      = mem_req_q && mem_ack;
  // Mode 1 is a single indirection; only modes 3, 5 and 7 read a pointer word first
  wire             ptr_def  = cur_def && (cur_mode != OAG_M_REGDEF);
  // A byte at an odd address rides in the upper lane of the word bus
  wire [15:0]      rd_val   = (byte_op && mem_addr_q[0]) ? {8'h00, mem_rdata[15:8]} : mem_rdata;
  wire             last_src = !side_q && two_operand;
  wire [15:0]      alu_res;

  oag_alu u_alu (
    .op      (op),
    .byte_op (byte_op),
    .src     (src_val_q),
    .dst     (dst_val_q),
    .res     (alu_res)
  );

  // Byte op on a register merges the low byte only
  wire [15:0] reg_wr = byte_op ? {dst_val_q[15:8], alu_res[7:0]} : alu_res;

  integer i;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q     <= S_IDLE;
      side_q      <= 1'b0;
      ea_q        <= 16'h0000;
      src_val_q   <= 16'h0000;
      dst_val_q   <= 16'h0000;
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_byte_q  <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      done_q      <= 1'b0;
      for (i = 0; i < 8; i = i + 1) gpr_q[i] <= `OAG_REG_RST;
    end else if (clk_en) begin
      done_q <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            side_q  <= !two_operand;
            state_q <= S_SEL;
          end
        end
        S_SEL: begin
          if (is_reg) begin
            // Register operand needs no memory cycle
            if (side_q) dst_val_q <= cur_rv;
            else src_val_q <= cur_rv;
            state_q <= side_q ? S_ALU : S_SEL;
            side_q  <= 1'b1;
          end else if (is_dec) begin
            gpr_q[cur_reg] <= dec_val;
            ea_q    <= dec_val;
            state_q <= S_PRE;
          end else if (is_idx) begin
            mem_req_q  <= 1'b1;
            mem_we_q   <= 1'b0;
            mem_byte_q <= 1'b0;
            mem_addr_q <= pc_v;
            state_q    <= S_EXT;
          end else begin
            ea_q <= cur_rv;
            if (is_inc) gpr_q[cur_reg] <= inc_val;
            state_q <= S_PRE;
          end
        end
        S_PRE: begin
          mem_req_q  <= 1'b1;
          mem_we_q   <= 1'b0;
          mem_byte_q <= !word_acc && !ptr_def;
          mem_addr_q <= ptr_def ? ea_q : opnd_ea;
          state_q    <= ptr_def ? S_PTR : S_OPND;
        end
        S_EXT: if (ack) begin
          mem_req_q <= 1'b0;
          gpr_q[`OAG_PC_IDX] <= pc_v + `OAG_STEP_WORD;
          ea_q      <= mem_rdata + cur_rv;
          state_q   <= S_PRE;
        end
        S_PTR: if (ack) begin
          // Pointer word read, then operand at that address
          mem_req_q <= 1'b0;
          ea_q      <= mem_rdata;
          side_q    <= side_q;
          state_q   <= S_OPND;
        end
        S_OPND: begin
          if (!mem_req_q) begin
            mem_req_q  <= 1'b1;
            mem_byte_q <= byte_op;
            mem_addr_q <= opnd_ea;
          end else if (mem_ack) begin
            mem_req_q <= 1'b0;
            if (side_q) dst_val_q <= rd_val;
            else src_val_q <= rd_val;
            state_q <= side_q ? S_ALU : S_SEL;
            side_q  <= 1'b1;
          end
        end
        S_ALU: begin
          if (d_mode == OAG_M_REG) begin
            gpr_q[d_reg] <= reg_wr;
            state_q      <= S_DONE;
          end else begin
            mem_req_q   <= 1'b1;
            mem_we_q    <= 1'b1;
            mem_byte_q  <= byte_op;
            mem_addr_q  <= opnd_ea;
            mem_wdata_q <= byte_op ? {alu_res[7:0], alu_res[7:0]} : alu_res;
            state_q     <= S_WR;
          end
        end
        S_WR: if (ack) begin
          mem_req_q <= 1'b0;
          mem_we_q  <= 1'b0;
          state_q   <= S_DONE;
        end
        S_DONE: begin
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign mem_req   = mem_req_q;
  assign mem_we    = mem_we_q;
  assign mem_addr  = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign mem_byte  = mem_byte_q;
  assign done      = done_q;
  logic [15:0] pc_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) pc_q <= `OAG_PC_RST;
    else if (clk_en) pc_q <= gpr_q[`OAG_PC_IDX];
  end
  assign pc_out = pc_q;

  // Helper: request holds until taken
  a_req_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    (mem_req && !mem_ack && clk_en) |=> mem_req)
    else $error("memory request dropped before ack");
  a_pc_step: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && state_q == S_EXT && mem_ack) |=> gpr_q[`OAG_PC_IDX] == $past(pc_v) + 16'h0002)
    else $error("pc not advanced by two");
  a_word_even: assert property (@(posedge mclk) disable iff (sys_rst)
    (mem_req && !mem_byte) |-> !mem_addr[0])
    else $error("odd word address");
  a_ext_from_pc: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_q == S_EXT && mem_req) |-> mem_addr == pc_v)
    else $error("extension word not fetched at pc");
  a_dec_first: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && state_q == S_SEL && is_dec) |=> ea_q == $past(dec_val) && state_q == S_PRE)
    else $error("autodecrement address wrong");
  a_inc_after: assert property (@(posedge mclk) disable iff (sys_rst)
    (clk_en && state_q == S_SEL && is_inc) |=> ea_q == $past(cur_rv))
    else $error("autoincrement used stepped value");
  a_def_step: assert property (@(posedge mclk) disable iff (sys_rst)
    (cur_def && !is_reg && (is_inc || is_dec)) |-> cur_step == 16'h0002)
    else $error("deferred step not two");
  a_done_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
    done |=> !done)
    else $error("done longer than one cycle");
endmodule

// ==== test/oag_mem_model.sv ====
`timescale 1ns/10ps
// Word-wide memory; a byte write lands only in the lane picked by address bit 0
module oag_mem_model (
  input  wire logic        mclk,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        mem_byte,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [logic [15:0]];
  logic [15:0] wa;
  logic [1:0]  wait_q;
  assign wa = {mem_addr[15:1], 1'b0};
  // Off-ack data is scrambled so an early or late sample never looks right
  assign mem_rdata = mem_ack ? mem[wa] : ~mem[wa] ^ {8'h00, wait_q, 6'h15};
  initial begin
    mem_ack = 1'b0;
    wait_q = 2'h0;
  end
  always @(posedge mclk) begin
    if (mem_ack) begin
      if (mem_we && !mem_byte)
        mem[wa] = mem_wdata;
      if (mem_we && mem_byte && mem_addr[0])
        mem[wa][15:8] = mem_wdata[15:8];
      if (mem_we && mem_byte && !mem_addr[0])
        mem[wa][7:0] = mem_wdata[7:0];
      mem_ack <= 1'b0;
    end else if (mem_req && wait_q >= (slow ? 2'h3 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
    end else if (mem_req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// ==== test/oag_operand_addr_gen_test.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module oag_operand_addr_gen_test;
  import oag_pkg::*;
  logic        mclk = 0, sys_rst = 1, clk_en = 1, start = 0, two_operand = 0;
  logic        byte_op = 0, slow = 0, mem_ack, mem_req, mem_we, mem_byte, done;
  logic [5:0]  src_spec = 6'h00, dst_spec = 6'h00;
  logic [15:0] mem_rdata, mem_addr, mem_wdata, pc_out;
  oag_op_t     op = OAG_OP_ZERO;
  int          miscompares = 0, num_checks = 0;

  oag_operand_addr_gen oag_operand_addr_gen_i (.mclk(mclk), .sys_rst(sys_rst),
    .clk_en(clk_en), .start(start), .src_spec(src_spec), .dst_spec(dst_spec),
    .two_operand(two_operand), .op(op), .byte_op(byte_op), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_byte(mem_byte), .done(done), .pc_out(pc_out));
  oag_mem_model oag_mem_model_i (.mclk(mclk), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_byte(mem_byte),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Inputs stay put from start until done, as the block expects
  task automatic run(input logic [5:0] s, input logic [5:0] d, input oag_op_t o,
                     input logic b);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    src_spec = s;
    dst_spec = d;
    op = o;
    byte_op = b;
    two_operand = (o == OAG_OP_ADD);
    start = 1'b1;
    @(posedge mclk);
    #1;
    start = 1'b0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 300)
      `CHK(done, 1'b1)
    @(posedge mclk);
    #1;
  endtask

  function automatic logic [15:0] rd(input logic [15:0] a);
    return oag_mem_model_i.mem[a];
  endfunction

  // Immediate adds are how the registers first get a value
  task automatic t_load;
    run(6'h17, 6'h01, OAG_OP_ADD, 1'b0);
    run(6'h17, 6'h02, OAG_OP_ADD, 1'b1);
    run(6'h17, 6'h06, OAG_OP_ADD, 1'b0);
    `CHK(pc_out, 16'h0006)
  endtask

  task automatic t_byte_reg;
    run(6'h00, 6'h02, OAG_OP_INVERT, 1'b1);
    run(6'h02, 6'h30, OAG_OP_ADD, 1'b0);
    `CHK(rd(16'h0400), 16'h00cb)
    `CHK(pc_out, 16'h0008)
  endtask

  task automatic t_autoinc;
    run(6'h00, 6'h09, OAG_OP_INVERT, 1'b0);
    `CHK(rd(16'h0200), 16'ha5a5)
    run(6'h00, 6'h11, OAG_OP_PLUS_ONE, 1'b1);
    run(6'h00, 6'h11, OAG_OP_PLUS_ONE, 1'b1);
    `CHK(rd(16'h0200), 16'ha6a6)
    run(6'h00, 6'h16, OAG_OP_PLUS_ONE, 1'b1);
    run(6'h00, 6'h16, OAG_OP_PLUS_ONE, 1'b1);
    `CHK(rd(16'h0300), 16'h0000)
    `CHK(rd(16'h0302), 16'h0011)
  endtask

  task automatic t_autodec;
    slow = 1'b1;
    run(6'h00, 6'h21, OAG_OP_ZERO, 1'b0);
    `CHK(rd(16'h0200), 16'h0000)
    `CHK(rd(16'h0202), 16'h7777)
    run(6'h00, 6'h29, OAG_OP_PLUS_ONE, 1'b1);
    `CHK(rd(16'h0500), 16'h0042)
    run(6'h00, 6'h19, OAG_OP_INVERT, 1'b1);
    `CHK(rd(16'h0500), 16'h00bd)
    run(6'h00, 6'h09, OAG_OP_PLUS_ONE, 1'b0);
    `CHK(rd(16'h0200), 16'h0001)
    slow = 1'b0;
  endtask

  task automatic t_index;
    run(6'h00, 6'h39, OAG_OP_ZERO, 1'b0);
    `CHK(rd(16'h0600), 16'h0000)
    `CHK(rd(16'h0210), 16'h0600)
    run(6'h31, 6'h36, OAG_OP_ADD, 1'b0);
    `CHK(rd(16'h0324), 16'h0105)
    `CHK(rd(16'h0230), 16'h0005)
    run(6'h11, 6'h30, OAG_OP_ADD, 1'b0);
    `CHK(rd(16'h0420), 16'h0011)
    run(6'h00, 6'h09, OAG_OP_INVERT, 1'b0);
    `CHK(rd(16'h0202), 16'h8888)
    `CHK(pc_out, 16'h0010)
    // Register two holds an odd value here, so the word address must drop bit 0
    run(6'h00, 6'h0a, OAG_OP_INVERT, 1'b0);
    `CHK(rd(16'h00ca), 16'hf0f0)
  endtask

  initial begin
    logic [15:0] a [18] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008,
      16'h000a, 16'h000c, 16'h000e, 16'h0200, 16'h0202, 16'h0300, 16'h0302,
      16'h0400, 16'h01fe, 16'h0500, 16'h0210, 16'h0600, 16'h0230};
    logic [15:0] v [18] = '{16'h0200, 16'h1234, 16'h0300, 16'h0400, 16'h0010,
      16'h0030, 16'h0020, 16'h0420, 16'h5a5a, 16'h7777, 16'h00ff, 16'h0010,
      16'h0000, 16'h0500, 16'h0041, 16'h0600, 16'hffff, 16'h0005};
    for (int i = 0; i < 18; i++) begin
      oag_mem_model_i.mem[a[i]] = v[i];
    end
    oag_mem_model_i.mem[16'h0324] = 16'h0100;
    oag_mem_model_i.mem[16'h0420] = 16'h0010;
    oag_mem_model_i.mem[16'h00ca] = 16'h0f0f;
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    t_load();
    t_byte_reg();
    t_autoinc();
    t_autodec();
    t_index();
    complete_run();
  end

  // Nineteen operations of under 40 cycles each fit well inside this span
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
